// *** src/tmt_edge.sv ***
// Pin synchroniser with once-per-machine-cycle falling edge detection
`timescale 1ns/1ps
module tmt_edge (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic sample_p,
    output logic      level,
    output logic      fall_p
);

    logic sync1_r;
    logic sync2_r;
    logic sample_r;

    // Two flip-flop synchroniser
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
        end
    end

    // Keep the previous machine cycle sample
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sample_r <= 1'b0;
        end else if (sample_p) begin
            sample_r <= sync2_r;
        end
    end

    // High in one sample, low in the next
    always_comb begin
        level  = sync2_r;
        fall_p = sample_p & sample_r & ~sync2_r;
    end

endmodule : tmt_edge

// *** src/tmt_phase.sv ***
// Machine cycle phase generator for the timer
`timescale 1ns/1ps
module tmt_phase
    import tmt_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    output logic      update_p,
    output logic      sample_p,
    output logic      state_p
);

    logic [3:0] phase_r;

    // Oscillator period counter within one machine cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= 4'h0;
        end else if (phase_r == PHASE_LAST) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // Phase strobes: update, sample and every state time
    always_comb begin
        update_p = (phase_r == UPDATE_SLOT);
        sample_p = (phase_r == SAMPLE_SLOT);
        state_p  = phase_r[0];
    end

endmodule : tmt_phase

// *** src/tmt_pkg.sv ***
// Constants, register map and mode type for the capture/reload timer
package tmt_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] OFS_CONTROL   = 8'hc8;
    localparam logic [7:0] OFS_COUNT_LO  = 8'hd0;
    localparam logic [7:0] OFS_COUNT_HI  = 8'hd4;
    localparam logic [7:0] OFS_CAPT_LO   = 8'hd8;
    localparam logic [7:0] OFS_CAPT_HI   = 8'hdc;
    localparam logic [7:0] OFS_MODE      = 8'he0;

    // ****************************************
    // Control and mode register fields, reset values and count limit
    // ****************************************
    localparam int BIT_OVF_FLAG  = 7;
    localparam int BIT_EXT_FLAG  = 6;
    localparam int BIT_RX_SEL    = 5;
    localparam int BIT_TX_SEL    = 4;
    localparam int BIT_EXT_EN    = 3;
    localparam int BIT_RUN       = 2;
    localparam int BIT_CTR_SEL   = 1;
    localparam int BIT_CAP_SEL   = 0;
    localparam int BIT_UPDOWN    = 0;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // ****************************************
    // Timing: oscillator periods per machine cycle and phase slots
    // ****************************************
    localparam int          OSC_PER_MACHINE = 12;
    localparam int          OSC_PER_STATE   = 2;
    localparam logic [3:0]  PHASE_LAST      = 4'(OSC_PER_MACHINE - 1);
    localparam logic [3:0]  UPDATE_SLOT     = 4'h4;
    localparam logic [3:0]  SAMPLE_SLOT     = 4'h9;

    // Operating mode, Gray coded
    typedef enum logic [1:0] {
        MODE_OFF     = 2'b00,
        MODE_RELOAD  = 2'b01,
        MODE_CAPTURE = 2'b11,
        MODE_BAUD    = 2'b10
    } tmt_mode_e;

endpackage : tmt_pkg

// *** src/tmt_timer.sv ***
// 16-bit capture/reload timer/counter with APB registers
`timescale 1ns/1ps
module tmt_timer
    import tmt_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_pin,
    input  wire logic        trigger_input_pin,
    input  wire logic        other_timer_ovf,
    output logic             rx_clock_pulse_r,
    output logic             tx_clock_pulse_r,
    output logic             timer_irq_r
);

    // ****************************************
    // Declarations
    // ****************************************
    logic        update_p;
    logic        sample_p;
    logic        state_p;
    logic        cnt_fall_p;
    logic        trg_fall_p;
    logic        trg_level;
    logic        cnt_pend_r;
    logic        trg_pend_r;
    logic        ovf_flag_r;
    logic        ext_flag_r;
    logic [5:0]  ctl_r;
    logic        updown_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] capt_r;
    logic [15:0] capt_nxt;
    tmt_mode_e   mode;
    logic        run;
    logic        baud;
    logic        ud_mode;
    logic        tick;
    logic        trg;
    logic        down;
    logic        ovf_up;
    logic        unf;
    logic        acc;
    logic        wr;
    logic        hit;
    logic        wr_ctl;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        wr_cap_lo;
    logic        wr_cap_hi;
    logic        wr_mode;
    logic [31:0] rd_data;

    // ****************************************
    // Phase and pin edge logic
    // ****************************************
    tmt_phase u_phase (
        .clock    (clock),
        .rst_n    (rst_n),
        .update_p (update_p),
        .sample_p (sample_p),
        .state_p  (state_p)
    );

    // Count pin edge detect
    tmt_edge u_cnt_edge (
        .clock    (clock),
        .rst_n    (rst_n),
        .pin      (count_input_pin),
        .sample_p (sample_p),
        .level    (),
        .fall_p   (cnt_fall_p)
    );

    // Trigger pin edge detect
    tmt_edge u_trg_edge (
        .clock    (clock),
        .rst_n    (rst_n),
        .pin      (trigger_input_pin),
        .sample_p (sample_p),
        .level    (trg_level),
        .fall_p   (trg_fall_p)
    );

    // Detected edges wait for the next update phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_pend_r <= 1'b0;
            trg_pend_r <= 1'b0;
        end else begin
            cnt_pend_r <= cnt_fall_p | (cnt_pend_r & ~update_p);
            trg_pend_r <= trg_fall_p | (trg_pend_r & ~update_p);
        end
    end

    // ****************************************
    // Mode decode and count events
    // ****************************************
    always_comb begin
        run  = ctl_r[BIT_RUN];
        baud = ctl_r[BIT_RX_SEL] | ctl_r[BIT_TX_SEL];
        if (!run) begin
            mode = MODE_OFF;
        end else if (baud) begin
            mode = MODE_BAUD;
        end else if (ctl_r[BIT_CAP_SEL]) begin
            mode = MODE_CAPTURE;
        end else begin
            mode = MODE_RELOAD;
        end
        ud_mode = updown_r & (mode == MODE_RELOAD);
        // Clock source selection
        if (ctl_r[BIT_CTR_SEL]) begin
            tick = cnt_pend_r & update_p;
        end else if (baud) begin
            tick = state_p;
        end else begin
            tick = update_p;
        end
        tick = tick & run;
        trg  = run & ctl_r[BIT_EXT_EN] & trg_pend_r & update_p;
        down   = ud_mode & ~trg_level;
        ovf_up = tick & ~down & (count_r == COUNT_MAX);
        unf    = tick & down & (count_r == capt_r);
    end

    // Next count and capture values
    always_comb begin
        count_nxt = count_r;
        capt_nxt  = capt_r;
        if (tick) begin
            if (unf) begin
                count_nxt = COUNT_MAX;
            end else if (down) begin
                count_nxt = count_r - 16'h0001;
            end else if (ovf_up && mode != MODE_CAPTURE) begin
                count_nxt = capt_r;
            end else begin
                count_nxt = count_r + 16'h0001;
            end
        end
        if (trg && mode == MODE_CAPTURE) begin
            capt_nxt = count_r;
        end
        if (trg && mode == MODE_RELOAD && !updown_r) begin
            count_nxt = capt_r;
        end
    end

    // Count bytes; a software write wins over hardware
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= COUNT_RESET;
        end else begin
            count_r[7:0]  <= wr_cnt_lo ? pwdata[7:0] : count_nxt[7:0];
            count_r[15:8] <= wr_cnt_hi ? pwdata[7:0] : count_nxt[15:8];
        end
    end

    // Capture bytes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            capt_r <= COUNT_RESET;
        end else begin
            capt_r[7:0]  <= wr_cap_lo ? pwdata[7:0] : capt_nxt[7:0];
            capt_r[15:8] <= wr_cap_hi ? pwdata[7:0] : capt_nxt[15:8];
        end
    end

    // ****************************************
    // Control register and flags
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r    <= CONTROL_RESET[5:0];
            updown_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_r <= pwdata[5:0];
            end
            if (wr_mode) begin
                updown_r <= pwdata[BIT_UPDOWN];
            end
        end
    end

    // Overflow flag: hardware set wins over software clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag_r <= CONTROL_RESET[BIT_OVF_FLAG];
        end else if ((ovf_up | unf) & ~baud) begin
            ovf_flag_r <= 1'b1;
        end else if (wr_ctl) begin
            ovf_flag_r <= pwdata[BIT_OVF_FLAG];
        end
    end

    // External flag: set by trigger, toggled in up/down mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_flag_r <= CONTROL_RESET[BIT_EXT_FLAG];
        end else if (ud_mode & (ovf_up | unf)) begin
            ext_flag_r <= ~ext_flag_r;
        end else if (trg & ~ud_mode) begin
            ext_flag_r <= 1'b1;
        end else if (wr_ctl) begin
            ext_flag_r <= pwdata[BIT_EXT_FLAG];
        end
    end

    // ****************************************
    // Serial clock routing and interrupt request
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_clock_pulse_r <= 1'b0;
            tx_clock_pulse_r <= 1'b0;
            timer_irq_r      <= 1'b0;
        end else begin
            rx_clock_pulse_r <= ctl_r[BIT_RX_SEL] ? (ovf_up & baud) : other_timer_ovf;
            tx_clock_pulse_r <= ctl_r[BIT_TX_SEL] ? (ovf_up & baud) : other_timer_ovf;
            timer_irq_r      <= ovf_flag_r | (ext_flag_r & ~updown_r);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        acc       = psel & penable & pready;
        wr        = acc & pwrite;
        hit       = 1'b1;
        rd_data   = 32'h0000_0000;
        wr_ctl    = 1'b0;
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        wr_cap_lo = 1'b0;
        wr_cap_hi = 1'b0;
        wr_mode   = 1'b0;
        case (paddr)
            OFS_CONTROL: begin
                rd_data[7:0] = {ovf_flag_r, ext_flag_r, ctl_r};
                wr_ctl       = wr;
            end
            OFS_COUNT_LO: begin
                rd_data[7:0] = count_r[7:0];
                wr_cnt_lo    = wr;
            end
            OFS_COUNT_HI: begin
                rd_data[7:0] = count_r[15:8];
                wr_cnt_hi    = wr;
            end
            OFS_CAPT_LO: begin
                rd_data[7:0] = capt_r[7:0];
                wr_cap_lo    = wr;
            end
            OFS_CAPT_HI: begin
                rd_data[7:0] = capt_r[15:8];
                wr_cap_hi    = wr;
            end
            OFS_MODE: begin
                rd_data[0] = updown_r;
                wr_mode    = wr;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // No wait states: ready and data are registered in the setup cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready & ~hit;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ovf_sets_flag_a: assert property ((ovf_up && !baud) |=> ovf_flag_r)
        else $error("overflow did not set overflow flag");
    baud_no_flag_a: assert property ((baud && !ovf_flag_r && !wr_ctl) |=> !ovf_flag_r)
        else $error("overflow flag set in baud mode");
    off_holds_a: assert property ((!run && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(count_r))
        else $error("count moved while stopped");
    machine_rate_a: assert property ((tick && !baud && !wr_ctl) |=> (!tick)[*8])
        else $error("count stepped faster than machine cycle");
    count_phase_a: assert property ((tick && ctl_r[BIT_CTR_SEL]) |-> update_p)
        else $error("pin count outside update phase");
    capture_copy_a: assert property ((trg && mode == MODE_CAPTURE && !wr_cap_lo && !wr_cap_hi)
        |=> capt_r == $past(count_r))
        else $error("capture did not copy count");
    reload_a: assert property ((ovf_up && (mode == MODE_RELOAD || baud) && !wr_cnt_lo && !wr_cnt_hi)
        |=> count_r == $past(capt_r))
        else $error("overflow did not reload count");
    trig_ignored_a: assert property ((!ctl_r[BIT_EXT_EN] && !ext_flag_r && !wr_ctl && !ud_mode)
        |=> !ext_flag_r)
        else $error("trigger seen while disabled");
    baud_rate_a: assert property ((run && baud && !ctl_r[BIT_CTR_SEL] && !wr_ctl) |-> ##[0:1] tick)
        else $error("baud timer missed a state time");

    capture_c: cover property (trg && mode == MODE_CAPTURE);
    baud_ovf_c: cover property (ovf_up && baud);
    underflow_c: cover property (unf);
    pin_count_c: cover property (tick && ctl_r[BIT_CTR_SEL]);

endmodule : tmt_timer

// *** tb/test_timer2_capture_reload_counter.sv ***
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module test_timer2_capture_reload_counter
    import tmt_pkg::*;
;
    logic        clock       = 1'b0;
    logic        rst_n       = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnt_pin;
    logic        trg_pin;
    logic        oth_ovf;
    logic        rx_pulse;
    logic        tx_pulse;
    logic        irq;
    logic [31:0] rd_data;
    logic        rd_err;
    int          rx_seen;
    int          tx_seen;
    int          bad_count   = 0;
    int          check_count = 0;

    tmt_timer u_dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_input_pin(cnt_pin),
        .trigger_input_pin(trg_pin), .other_timer_ovf(oth_ovf),
        .rx_clock_pulse_r(rx_pulse), .tx_clock_pulse_r(tx_pulse),
        .timer_irq_r(irq)
    );

    tmt_pins_model u_pins (
        .clock(clock), .rx_clock_pulse_r(rx_pulse), .tx_clock_pulse_r(tx_pulse),
        .count_input_pin(cnt_pin), .trigger_input_pin(trg_pin),
        .other_timer_ovf(oth_ovf), .rx_seen(rx_seen), .tx_seen(tx_seen)
    );

    // 20 MHz clock
    always #25 clock = ~clock;

    // ****************************************
    // Checks, bus cycles and reference model
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Setup cycle, then access until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_data, {24'h0, exp});
    endtask : rd

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h04, v[15:8]);
    endtask : wr16

    task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
        rd(a, exp[7:0]);
        rd(a + 8'h04, exp[15:8]);
    endtask : rd16

    // Count after n steps, reloading from the capture value past ffff
    function automatic int model_steps(int c, int cap, int n);
        for (int i = 0; i < n; i++)
            c = (c == 32'hffff) ? cap : c + 1;
        return c;
    endfunction : model_steps

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        wrap_up();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [15:0] v;
        logic [15:0] cap;
        int          n;
        int          r0;
        int          t0;
        v = 16'($urandom(32'h528a));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_CONTROL, CONTROL_RESET);
        apb(1'b0, 8'h00, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        chk(rd_data, 32'h0);
        wr(OFS_CONTROL, 8'h3b);
        rd(OFS_CONTROL, 8'h3b);
        // Timer run of exactly 60 clocks across an overflow
        cap = 16'hff00 | {8'h00, v[7:0]};
        wr16(OFS_CAPT_LO, cap);
        wr16(OFS_COUNT_LO, 16'hfffd);
        wr(OFS_CONTROL, 8'h04);
        repeat (54) @(posedge clock);
        rd(OFS_CONTROL, 8'h84);
        wr(OFS_CONTROL, 8'h80);
        rd16(OFS_COUNT_LO, 16'(model_steps(32'hfffd, int'(cap), 5)));
        chk({31'h0, irq}, 32'h1);
        wr(OFS_CONTROL, 8'h00);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        // Counter on pin edges at the top rate
        v = 16'($urandom) & 16'h7fff;
        n = 1 + int'($urandom % 6);
        wr16(OFS_COUNT_LO, v);
        wr(OFS_CONTROL, 8'h06);
        u_pins.count_pulses(n);
        repeat (12) @(posedge clock);
        wr(OFS_CONTROL, 8'h02);
        rd16(OFS_COUNT_LO, 16'(model_steps(int'(v), 0, n)));
        // Capture on a trigger edge
        v = 16'($urandom);
        wr16(OFS_COUNT_LO, v);
        wr16(OFS_CAPT_LO, ~v);
        wr(OFS_CONTROL, 8'h0f);
        u_pins.trig_fall();
        rd16(OFS_CAPT_LO, v);
        rd16(OFS_COUNT_LO, v);
        rd(OFS_CONTROL, 8'h4f);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_MODE, 8'h01);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        // Up/down: low trigger level counts down through the capture value, 36 clocks run
        wr(OFS_CONTROL, 8'h00);
        cap = 16'($urandom) & 16'h7fff;
        wr16(OFS_CAPT_LO, cap);
        wr16(OFS_COUNT_LO, cap + 16'h0001);
        u_pins.trig_hold(1'b0);
        wr(OFS_CONTROL, 8'h04);
        repeat (30) @(posedge clock);
        rd(OFS_CONTROL, 8'hc4);
        wr(OFS_CONTROL, 8'h40);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rd16(OFS_COUNT_LO, 16'hfffe);
        u_pins.trig_hold(1'b1);
        wr(OFS_MODE, 8'h00);
        // Trigger ignored, then reloading, then flag only in baud mode
        cap = 16'($urandom);
        wr16(OFS_CAPT_LO, cap);
        wr16(OFS_COUNT_LO, 16'h0042);
        wr(OFS_CONTROL, 8'h06);
        u_pins.trig_fall();
        rd16(OFS_COUNT_LO, 16'h0042);
        rd(OFS_CONTROL, 8'h06);
        wr(OFS_CONTROL, 8'h0e);
        u_pins.trig_fall();
        rd16(OFS_COUNT_LO, cap);
        rd(OFS_CONTROL, 8'h4e);
        wr16(OFS_COUNT_LO, 16'h0042);
        wr(OFS_CONTROL, 8'h2e);
        u_pins.trig_fall();
        rd16(OFS_COUNT_LO, 16'h0042);
        rd(OFS_CONTROL, 8'h6e);
        // Baud generator feeding one direction, other timer the other
        wr(OFS_CONTROL, 8'h00);
        cap = ($urandom % 2) ? 16'hfff8 : 16'hfff0;
        wr16(OFS_CAPT_LO, cap);
        wr16(OFS_COUNT_LO, cap);
        n = 320 / (2 * (65536 - int'(cap)));
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CONTROL, s ? 8'h15 : 8'h25);
            repeat (64) @(posedge clock);
            r0 = rx_seen;
            t0 = tx_seen;
            repeat (320) @(posedge clock);
            chk(32'(rx_seen - r0), 32'(s ? 8 : n));
            chk(32'(tx_seen - t0), 32'(s ? n : 8));
            rd(OFS_CONTROL, s ? 8'h15 : 8'h25);
        end
        wrap_up();
    end
endmodule : test_timer2_capture_reload_counter

// *** tb/tmt_pins_model.sv ***
// Far-side model: count pin, trigger pin, other timer and serial port
`timescale 1ns/1ps
module tmt_pins_model (
    input  wire logic clock,
    input  wire logic rx_clock_pulse_r,
    input  wire logic tx_clock_pulse_r,
    output logic      count_input_pin,
    output logic      trigger_input_pin,
    output logic      other_timer_ovf,
    output int        rx_seen,
    output int        tx_seen
);
    int ovf_div;

    // Port lines idle high, as if pulled up
    initial begin
        count_input_pin   = 1'b1;
        trigger_input_pin = 1'b1;
        other_timer_ovf   = 1'b0;
        rx_seen           = 0;
        tx_seen           = 0;
        ovf_div           = 0;
    end

    // Other timer overflows every 40 clocks; serial port counts its clocks
    always @(posedge clock) begin
        ovf_div         <= (ovf_div == 39) ? 0 : ovf_div + 1;
        other_timer_ovf <= (ovf_div == 39);
        rx_seen         <= rx_seen + int'(rx_clock_pulse_r === 1'b1);
        tx_seen         <= tx_seen + int'(tx_clock_pulse_r === 1'b1);
    end

    // Falling edges at the top rate, each level held one machine cycle
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge clock) count_input_pin <= 1'b0;
            repeat (12) @(posedge clock);
            count_input_pin <= 1'b1;
            repeat (11) @(posedge clock);
        end
    endtask : count_pulses

    // One trigger falling edge, both levels held two machine cycles
    task automatic trig_fall;
        @(posedge clock) trigger_input_pin <= 1'b0;
        repeat (24) @(posedge clock);
        trigger_input_pin <= 1'b1;
        repeat (24) @(posedge clock);
    endtask : trig_fall

    // Trigger pin to a steady level, held two machine cycles
    task automatic trig_hold(input logic lvl);
        @(posedge clock) trigger_input_pin <= lvl;
        repeat (24) @(posedge clock);
    endtask : trig_hold
endmodule : tmt_pins_model
